// File: dv/correlator_timebase_monitor.sv
`timescale 1ns/100ps
// ----------------------------------------
// timebase checker
// ----------------------------------------
module correlator_timebase_monitor
  import timebase_pkg::*;
#(
  parameter int CHANNELS = 12
) (
  input wire logic                      I_CLK,                    // master clock
  input wire logic                      I_RESETN,                 // hw reset, active low
  input wire logic [CHANNELS-1:0]       O_CHANNEL_WRITE_SELECT,   // write mask
  input wire logic [CHANNELS-1:0]       O_CHANNEL_RESET_N,        // channel resets
  input wire logic                      O_SOFT_MASTER_RESET_N,    // soft reset bit
  input wire timebase_pkg::input_mode_t O_INPUT_MODE,             // front-end mode
  input wire logic                      O_IRQ_ENABLE,             // global enable
  input wire logic                      O_PHASE_TICK,             // phase tick
  input wire logic                      O_ACCUMULATION_INTERRUPT, // interrupt pulse
  input wire logic                      O_MEAS_IRQ_ENABLE,        // measurement mask
  input wire logic                      O_EPOCH_PULSE             // epoch pulse
);
  default clocking mon_cb @(posedge I_CLK); endclocking
  default disable iff (!I_RESETN);
  logic [3:0]  gap_reg;
  logic [1:0]  age_reg;
  input_mode_t last_mode_reg;
  // cycles since the last phase tick
  always_ff @(posedge I_CLK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      gap_reg <= 4'h0;
    end else if (O_PHASE_TICK) begin
      gap_reg <= 4'h0;
    end else if (gap_reg != 4'hF) begin
      gap_reg <= gap_reg + 4'h1;
    end
  end
  // ticks since a mode change; the phase around a change may be short, so skip two
  always_ff @(posedge I_CLK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      age_reg <= 2'h0;
      last_mode_reg <= MODE_REAL;
    end else begin
      last_mode_reg <= O_INPUT_MODE;
      if (O_INPUT_MODE != last_mode_reg) begin
        age_reg <= 2'h0;
      end else if (O_PHASE_TICK && age_reg != 2'h2) begin
        age_reg <= age_reg + 2'h1;
      end
    end
  end
  a_phase_gap:
    assert property (O_PHASE_TICK && age_reg == 2'h2 |-> gap_reg == ((O_INPUT_MODE == MODE_COMPLEX) ? 4'h5 : 4'h6))
      else $error("phase tick spacing wrong");
  a_irq_masked:
    assert property (O_ACCUMULATION_INTERRUPT |-> O_IRQ_ENABLE || $past(O_IRQ_ENABLE))
      else $error("interrupt while disabled");
  a_meas_follows:
    assert property (O_MEAS_IRQ_ENABLE == $past(O_IRQ_ENABLE))
      else $error("measurement mask not following enable");
  a_irq_single:
    assert property (O_ACCUMULATION_INTERRUPT |=> !O_ACCUMULATION_INTERRUPT)
      else $error("interrupt pulse too long");
  a_epoch_single:
    assert property (O_EPOCH_PULSE |=> !O_EPOCH_PULSE)
      else $error("epoch pulse too long");
  a_soft_mask_clear:
    assert property (!O_SOFT_MASTER_RESET_N && !$past(O_SOFT_MASTER_RESET_N) |-> O_CHANNEL_WRITE_SELECT == '0)
      else $error("mask not cleared in soft reset");
  a_soft_chan_low:
    assert property (!O_SOFT_MASTER_RESET_N |-> O_CHANNEL_RESET_N == '0)
      else $error("channel reset bits high in soft reset");
  a_soft_setup_clear:
    assert property (!O_SOFT_MASTER_RESET_N && !$past(O_SOFT_MASTER_RESET_N) |-> !O_IRQ_ENABLE)
      else $error("enable not cleared in soft reset");
endmodule

bind correlator_timebase correlator_timebase_monitor #(.CHANNELS(CHANNELS)) u_mon (
  .I_CLK, .I_RESETN, .O_CHANNEL_WRITE_SELECT, .O_CHANNEL_RESET_N, .O_SOFT_MASTER_RESET_N, .O_INPUT_MODE,
  .O_IRQ_ENABLE, .O_PHASE_TICK, .O_ACCUMULATION_INTERRUPT, .O_MEAS_IRQ_ENABLE, .O_EPOCH_PULSE
);

// File: dv/correlator_timebase_test.sv
`timescale 1ns/100ps
`include "timebase_params.svh"
module correlator_timebase_test;
  import timebase_pkg::*;
  typedef struct packed {
    logic [15:0] data;
    logic [11:0] mask;
    logic [15:0] setup;
  } row_t;
  // mask data, expected mask, expected setup readback (data bit 5 is the enable)
  localparam row_t ROWS [3] = '{'{16'hFFFF, 12'hFFF, 16'h0020}, '{16'h0A5A, 12'hA5A, 16'h0000},
                               '{16'h0021, 12'h021, 16'h0020}};
  localparam int EP_P  = 9; // short epoch divider
  localparam int IRQ_P = 3; // short interrupt divider
  logic        I_CLK, I_RESETN, I_WR, I_RD;
  logic [7:0]  I_ADDR;
  logic [15:0] I_WDATA, I_FLAGS_FIRST, I_FLAGS_SECOND, I_FLAGS_THIRD, O_RDATA, O_SNAP_FIRST, O_SNAP_SECOND, O_SNAP_THIRD;
  logic [11:0] O_CHANNEL_WRITE_SELECT, O_CHANNEL_RESET_N, O_CHANNEL_RELEASE;
  logic        O_SOFT_MASTER_RESET_N, O_IRQ_ENABLE, O_PHASE_TICK, O_ACCUMULATION_INTERRUPT, O_MEAS_IRQ_ENABLE, O_EPOCH_PULSE;
  input_mode_t O_INPUT_MODE;
  int          err_total, n_tests, cyc, t0, t1;
  logic [15:0] v;
  correlator_timebase #(.CHANNELS(12)) DUT (
    .I_CLK, .I_RESETN, .I_ADDR, .I_WDATA, .I_WR, .I_RD, .I_FLAGS_FIRST, .I_FLAGS_SECOND, .I_FLAGS_THIRD,
    .O_RDATA, .O_CHANNEL_WRITE_SELECT, .O_CHANNEL_RESET_N, .O_CHANNEL_RELEASE, .O_SOFT_MASTER_RESET_N,
    .O_INPUT_MODE, .O_IRQ_ENABLE, .O_PHASE_TICK, .O_ACCUMULATION_INTERRUPT, .O_MEAS_IRQ_ENABLE,
    .O_EPOCH_PULSE, .O_SNAP_FIRST, .O_SNAP_SECOND, .O_SNAP_THIRD
  );
  // ----------------------------------------
  // clock, cycle count, watchdog
  // ----------------------------------------
  initial begin
    I_CLK = 1'b0;
    forever #5 I_CLK = ~I_CLK;
  end
  always @(posedge I_CLK) cyc <= cyc + 1;
  // whole run is about 73k cycles, mostly the two long interrupt periods
  initial begin
    #950_000;
    err_total++;
    $display("watchdog expired");
    summarize();
  end
  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // one-cycle write; returns just after the taking edge
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge I_CLK);
    I_WR <= 1'b1;
    I_ADDR <= a;
    I_WDATA <= d;
    @(posedge I_CLK);
    I_WR <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge I_CLK);
    I_RD <= 1'b1;
    I_ADDR <= a;
    @(posedge I_CLK);
    I_RD <= 1'b0;
    #1;
    v = O_RDATA;
  endtask
  // flags pattern a, ~a, a^00FF so every bit moves
  task automatic setf(input logic [15:0] a);
    @(posedge I_CLK);
    I_FLAGS_FIRST <= a;
    I_FLAGS_SECOND <= ~a;
    I_FLAGS_THIRD <= a ^ 16'h00FF;
  endtask
  task automatic snapchk(input logic [15:0] a);
    chk({O_SNAP_FIRST, O_SNAP_SECOND}, {a, ~a});
    chk(O_SNAP_THIRD, a ^ 16'h00FF);
  endtask
  task automatic wp(input logic sel, input int lim, output int at);
    at = -1;
    for (int i = 0; i < lim && at < 0; i++) begin
      @(posedge I_CLK);
      #1;
      if ((sel ? O_EPOCH_PULSE : O_ACCUMULATION_INTERRUPT) === 1'b1) at = cyc;
    end
    if (at < 0) begin
      err_total++;
      $display("pulse never came");
    end
  endtask
  // spacing of two pulses; the first may finish an old, longer count
  task automatic gap(input logic sel, input int exp);
    wp(sel, 25000, t0);
    wp(sel, 2 * exp + 100, t1);
    chk(t1 - t0, exp);
  endtask
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    {I_RESETN, I_WR, I_RD, I_ADDR, I_WDATA, err_total, n_tests} = '0;
    {I_FLAGS_FIRST, I_FLAGS_SECOND, I_FLAGS_THIRD} = {16'h0000, 16'hFFFF, 16'h00FF};
    repeat (11) @(posedge I_CLK);
    #1;
    chk(O_SOFT_MASTER_RESET_N, 1);
    chk(O_CHANNEL_WRITE_SELECT, 0);
    chk(O_CHANNEL_RESET_N, 0);
    chk(O_INPUT_MODE, MODE_REAL);
    chk(O_IRQ_ENABLE, 0);
    @(posedge I_CLK);
    I_RESETN <= 1'b1;
    // short presets must land before the first zero reload
    wr(`OFF_EPOCH_DIV_UPPER, 16'h0000);
    wr(`OFF_EPOCH_DIV_LOWER, 16'(EP_P));
    wr(`OFF_ACCUM_IRQ_DIV, 16'hE000 | 16'(IRQ_P));
    rd(`OFF_STATE_READBACK);
    chk(v, 16'h0000);
    foreach (ROWS[i]) begin
      wr(`OFF_MULTI_WRITE_MASK, ROWS[i].data);
      chk(O_CHANNEL_WRITE_SELECT, ROWS[i].mask);
      wr(`OFF_SYSTEM_SETUP, ROWS[i].data & 16'h0020);
      rd(`OFF_SYSTEM_SETUP);
      chk(v, ROWS[i].setup);
    end
    rd(8'h40);
    chk(v, 0);
    gap(1, (EP_P + 1) * 7);
    gap(0, (IRQ_P + 1) * 7);
    // snapshot with the enable low, then interrupt capture with it high
    wr(`OFF_SYSTEM_SETUP, 16'h0000);
    setf(16'h1234);
    repeat (80) @(posedge I_CLK);
    #1;
    snapchk(16'h0000);
    wr(`OFF_SNAPSHOT_TRIGGER, 16'h0000);
    snapchk(16'h1234);
    // flags settle before the enable, so the first capture sees them
    setf(16'h5A5A);
    wr(`OFF_SYSTEM_SETUP, 16'h0020);
    wp(0, 100, t0);
    snapchk(16'h5A5A);
    // channel resets and soft master reset
    wr(`OFF_CHAN_SOFT_RESET, 16'h1FFF);
    chk(O_CHANNEL_RESET_N, 12'hFFF);
    wr(`OFF_MULTI_WRITE_MASK, 16'h0FFF);
    wr(`OFF_CHAN_SOFT_RESET, 16'h1FFE);
    chk(O_CHANNEL_RESET_N, 0);
    chk(O_SOFT_MASTER_RESET_N, 0);
    wr(`OFF_MULTI_WRITE_MASK, 16'h0FFF);
    chk(O_CHANNEL_WRITE_SELECT, 0);
    wr(`OFF_ACCUM_IRQ_DIV, 16'h0001);
    gap(1, (EP_P + 1) * 7);
    wr(`OFF_CHAN_SOFT_RESET, 16'h000F);
    chk(O_CHANNEL_RELEASE, 12'h007);
    chk(O_CHANNEL_RESET_N, 12'h007);
    @(posedge I_CLK);
    #1;
    chk(O_CHANNEL_RELEASE, 12'h000);
    // refused divider write leaves the period; the gap also leaves the
    // counter just reloaded to IRQ_P, three ticks from zero, when the mode toggles
    wr(`OFF_SYSTEM_SETUP, 16'h0020);
    gap(0, (IRQ_P + 1) * 7);
    // mode and period edges rewrite the interrupt preset
    wr(`OFF_SYSTEM_SETUP, 16'h0060); // no lower write beside it
    chk(O_INPUT_MODE, MODE_COMPLEX);
    gap(0, (32'h0B81 + 1) * 6);
    wr(`OFF_SYSTEM_SETUP, 16'h00A0);
    gap(0, (32'h1313 + 1) * 7);
    // an upper write alone only arms the pending transfer
    wr(`OFF_EPOCH_DIV_UPPER, 16'h0003);
    rd(`OFF_STATE_READBACK);
    chk(v, 16'h000D);
    summarize();
  end
endmodule

// File: hw/correlator_timebase.sv
// The address map and the strobed register port are this design's own decisions.
`timescale 1ns/100ps
`include "timebase_params.svh"
module correlator_timebase
  import timebase_pkg::*;
#(
  parameter int CHANNELS = 12
) (
  input  wire logic                I_CLK,            // 100 MHz master clock
  input  wire logic                I_RESETN,         // async hardware reset, active low
  input  wire logic [7:0]          I_ADDR,           // register index
  input  wire logic [15:0]         I_WDATA,          // write data
  input  wire logic                I_WR,             // write strobe
  input  wire logic                I_RD,             // read strobe
  input  wire logic [15:0]         I_FLAGS_FIRST,    // live accum_flags_first
  input  wire logic [15:0]         I_FLAGS_SECOND,   // live accum_flags_second
  input  wire logic [15:0]         I_FLAGS_THIRD,    // live accum_flags_third
  output logic [15:0]              O_RDATA,          // read data, cycle after strobe
  output logic [CHANNELS-1:0]      O_CHANNEL_WRITE_SELECT, // multi-write mask
  output logic [CHANNELS-1:0]      O_CHANNEL_RESET_N,      // per-channel reset, low resets
  output logic [CHANNELS-1:0]      O_CHANNEL_RELEASE,      // pulse: restart code phase
  output logic                     O_SOFT_MASTER_RESET_N,  // soft master reset bit
  output timebase_pkg::input_mode_t O_INPUT_MODE,    // front-end mode
  output logic                     O_IRQ_ENABLE,     // global interrupt enable
  output logic                     O_PHASE_TICK,     // multi-phase clock cycle pulse
  output logic                     O_ACCUMULATION_INTERRUPT, // masked interrupt pulse
  output logic                     O_MEAS_IRQ_ENABLE,        // mask for measurement_interrupt
  output logic                     O_EPOCH_PULSE,    // epoch pulse
  output logic [15:0]              O_SNAP_FIRST,     // captured accum_flags_first
  output logic [15:0]              O_SNAP_SECOND,    // captured accum_flags_second
  output logic [15:0]              O_SNAP_THIRD      // captured accum_flags_third
);
  import timebase_pkg::*;

  // -------------------------------------------------
  // decode
  // -------------------------------------------------
  logic wr_setup;
  logic wr_mask;
  logic wr_irq_div;
  logic wr_upper;
  logic wr_lower;
  logic wr_reset;
  logic wr_snap;
  logic soft_ok;
  // with the soft reset bit low only the reset register takes writes
  assign soft_ok = O_SOFT_MASTER_RESET_N;

  // write decode; channel reset state never blocks a write
  always_comb begin
    wr_setup   = 1'b0;
    wr_mask    = 1'b0;
    wr_irq_div = 1'b0;
    wr_upper   = 1'b0;
    wr_lower   = 1'b0;
    wr_reset   = 1'b0;
    wr_snap    = 1'b0;
    if (!I_WR) begin
      wr_reset = 1'b0;
    end else if (I_ADDR == `OFF_CHAN_SOFT_RESET) begin
      wr_reset = 1'b1;
    end else if (!soft_ok) begin
      wr_reset = 1'b0;
    end else if (I_ADDR == `OFF_SYSTEM_SETUP) begin
      wr_setup = 1'b1;
    end else if (I_ADDR == `OFF_MULTI_WRITE_MASK) begin
      wr_mask = 1'b1;
    end else if (I_ADDR == `OFF_ACCUM_IRQ_DIV) begin
      wr_irq_div = 1'b1;
    end else if (I_ADDR == `OFF_EPOCH_DIV_UPPER) begin
      wr_upper = 1'b1;
    end else if (I_ADDR == `OFF_EPOCH_DIV_LOWER) begin
      wr_lower = 1'b1;
    end else if (I_ADDR == `OFF_SNAPSHOT_TRIGGER) begin
      wr_snap = 1'b1;
    end
  end

  // soft master reset acts while the bit is low
  logic soft_rst;
  assign soft_rst = !O_SOFT_MASTER_RESET_N;

  // -------------------------------------------------
  // reset control register
  // -------------------------------------------------
  // a low soft bit also forces every channel into reset
  always_ff @(posedge I_CLK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      O_SOFT_MASTER_RESET_N <= 1'b1;
      O_CHANNEL_RESET_N     <= '0;
    end else if (wr_reset) begin
      O_SOFT_MASTER_RESET_N <= I_WDATA[`BIT_SOFT_RESET_N];
      if (!I_WDATA[`BIT_SOFT_RESET_N]) begin
        O_CHANNEL_RESET_N <= '0;
      end else begin
        // low bit gates the channel clock phases downstream
        O_CHANNEL_RESET_N <= I_WDATA[CHANNELS:1];
      end
    end
  end

  // rising reset bits restart code generators together
  always_ff @(posedge I_CLK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      O_CHANNEL_RELEASE <= '0;
    end else if (wr_reset && I_WDATA[`BIT_SOFT_RESET_N]) begin
      O_CHANNEL_RELEASE <= I_WDATA[CHANNELS:1] & ~O_CHANNEL_RESET_N;
    end else begin
      O_CHANNEL_RELEASE <= '0;
    end
  end

  // -------------------------------------------------
  // mask and setup bits
  // -------------------------------------------------
  always_ff @(posedge I_CLK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      O_CHANNEL_WRITE_SELECT <= '0;
    end else if (soft_rst) begin
      O_CHANNEL_WRITE_SELECT <= '0;
    end else if (wr_mask) begin
      O_CHANNEL_WRITE_SELECT <= I_WDATA[CHANNELS-1:0];
    end
  end

  // setup bits are held clear every cycle while the soft bit is low;
  // a mode change there reloads both presets and a period change the interrupt preset, through the edges
  logic irq_period_reg;
  always_ff @(posedge I_CLK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      O_INPUT_MODE   <= MODE_REAL;
      irq_period_reg <= 1'b0;
      O_IRQ_ENABLE   <= 1'b0;
    end else if (soft_rst) begin
      O_INPUT_MODE   <= MODE_REAL;
      irq_period_reg <= 1'b0;
      O_IRQ_ENABLE   <= 1'b0;
    end else if (wr_setup) begin
      O_INPUT_MODE   <= input_mode_t'(I_WDATA[`BIT_FRONT_END_MODE]);
      irq_period_reg <= I_WDATA[`BIT_IRQ_PERIOD];
      O_IRQ_ENABLE   <= I_WDATA[`BIT_IRQ_ENABLE];
    end
  end

  // measurement interrupt mask follows the same enable
  always_ff @(posedge I_CLK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      O_MEAS_IRQ_ENABLE <= 1'b0;
    end else begin
      O_MEAS_IRQ_ENABLE <= O_IRQ_ENABLE;
    end
  end

  // edges seen on the stored bits, one cycle after they change
  // reset values match the idle levels, so no false edge after reset
  logic mode_d_reg;
  logic period_d_reg;
  logic mode_edge;
  logic period_edge;
  always_ff @(posedge I_CLK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      mode_d_reg   <= 1'b0;
      period_d_reg <= 1'b0;
    end else begin
      mode_d_reg   <= O_INPUT_MODE;
      period_d_reg <= irq_period_reg;
    end
  end
  assign mode_edge   = mode_d_reg != O_INPUT_MODE;
  assign period_edge = period_d_reg != irq_period_reg;

  // -------------------------------------------------
  // multi-phase clock divider
  // -------------------------------------------------
  logic [2:0] phase_reg;
  logic [2:0] phase_len;
  logic       phase_end;
  // timebase keeps running through a soft reset
  // after a mode change the >= compare ends an over-long phase at once
  assign phase_len = (O_INPUT_MODE == MODE_COMPLEX) ? `PHASE_LEN_CPLX : `PHASE_LEN_REAL;
  assign phase_end = phase_reg >= (phase_len - 3'h1);
  always_ff @(posedge I_CLK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      phase_reg <= '0;
    end else if (phase_end) begin
      phase_reg <= '0;
    end else begin
      phase_reg <= phase_reg + 3'h1;
    end
  end
  always_ff @(posedge I_CLK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      O_PHASE_TICK <= 1'b0;
    end else begin
      O_PHASE_TICK <= phase_end;
    end
  end

  // -------------------------------------------------
  // interrupt preset
  // -------------------------------------------------
  logic [12:0] irq_preset_reg;
  logic [12:0] irq_edge_value;
  always_comb begin
    irq_edge_value = `IRQ_PRESET_REAL_SHORT;
    if (O_INPUT_MODE == MODE_COMPLEX) begin
      irq_edge_value = irq_period_reg ? `IRQ_PRESET_CPLX_LONG : `IRQ_PRESET_CPLX_SHORT;
    end else begin
      irq_edge_value = irq_period_reg ? `IRQ_PRESET_REAL_LONG : `IRQ_PRESET_REAL_SHORT;
    end
  end
  // a soft reset reaches the timebase presets only through the mode and period edges
  always_ff @(posedge I_CLK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      irq_preset_reg <= `IRQ_PRESET_REAL_SHORT;
    end else if (wr_irq_div) begin
      irq_preset_reg <= I_WDATA[12:0];
    end else if (mode_edge || period_edge) begin
      irq_preset_reg <= irq_edge_value;
    end
  end

  // -------------------------------------------------
  // epoch preset and upper holding latch
  // -------------------------------------------------
  logic [20:0] epoch_preset_reg;
  logic [4:0]  epoch_upper_reg;
  logic        upper_pending_reg;
  always_ff @(posedge I_CLK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      epoch_upper_reg   <= '0;
      upper_pending_reg <= 1'b0;
    end else if (wr_upper) begin
      epoch_upper_reg   <= I_WDATA[4:0];
      upper_pending_reg <= 1'b1;
    end else if (wr_lower) begin
      upper_pending_reg <= 1'b0;
    end
  end
  // mode edge spacing against lower writes is left to software
  always_ff @(posedge I_CLK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      epoch_preset_reg <= `EPOCH_PRESET_REAL;
    end else if (wr_lower && upper_pending_reg) begin
      epoch_preset_reg <= {epoch_upper_reg, I_WDATA};
    end else if (wr_lower) begin
      epoch_preset_reg <= {epoch_preset_reg[20:16], I_WDATA};
    end else if (mode_edge) begin
      epoch_preset_reg <= (O_INPUT_MODE == MODE_COMPLEX) ? `EPOCH_PRESET_CPLX : `EPOCH_PRESET_REAL;
    end
  end

  // -------------------------------------------------
  // counters
  // -------------------------------------------------
  // both counters share one phase tick, so interrupt and epoch stay
  // locked to a single timebase
  logic irq_zero;
  logic epoch_zero;
  reload_down_counter #(.WIDTH(13)) u_irq_counter (
    .i_clk    (I_CLK),
    .i_resetn (I_RESETN),
    .i_tick   (phase_end),
    .i_preset (irq_preset_reg),
    .o_zero   (irq_zero)
  );
  reload_down_counter #(.WIDTH(21)) u_epoch_counter (
    .i_clk    (I_CLK),
    .i_resetn (I_RESETN),
    .i_tick   (phase_end),
    .i_preset (epoch_preset_reg),
    .o_zero   (epoch_zero)
  );
  always_ff @(posedge I_CLK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      O_ACCUMULATION_INTERRUPT <= 1'b0;
      O_EPOCH_PULSE            <= 1'b0;
    end else begin
      O_ACCUMULATION_INTERRUPT <= irq_zero && O_IRQ_ENABLE;
      O_EPOCH_PULSE            <= epoch_zero;
    end
  end

  // -------------------------------------------------
  // status snapshot
  // -------------------------------------------------
  // flags come from the same clock, so no synchroniser; mixing both
  // capture sources gives confused readings, software must choose one
  always_ff @(posedge I_CLK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      O_SNAP_FIRST  <= '0;
      O_SNAP_SECOND <= '0;
      O_SNAP_THIRD  <= '0;
    end else if (wr_snap || (irq_zero && O_IRQ_ENABLE)) begin
      O_SNAP_FIRST  <= I_FLAGS_FIRST;
      O_SNAP_SECOND <= I_FLAGS_SECOND;
      O_SNAP_THIRD  <= I_FLAGS_THIRD;
    end
  end

  // -------------------------------------------------
  // readback
  // -------------------------------------------------
  // read data stands one cycle, zero otherwise, so a read of a
  // write-only register returns a clean zero
  always_ff @(posedge I_CLK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      O_RDATA <= '0;
    end else if (I_RD && (I_ADDR == `OFF_STATE_READBACK)) begin
      O_RDATA <= {12'h000, upper_pending_reg, irq_period_reg, O_INPUT_MODE, O_IRQ_ENABLE};
    end else if (I_RD && (I_ADDR == `OFF_SYSTEM_SETUP)) begin
      O_RDATA <= {8'h00, irq_period_reg, O_INPUT_MODE, O_IRQ_ENABLE, 5'h00};
    end else begin
      O_RDATA <= '0;
    end
  end
endmodule

// File: hw/reload_down_counter.sv
`timescale 1ns/100ps
// reload down counter: pulse and reload on zero
module reload_down_counter #(
  parameter int WIDTH = 13
) (
  input  wire logic             i_clk,      // master clock
  input  wire logic             i_resetn,   // async reset, active low
  input  wire logic             i_tick,     // one multi-phase cycle
  input  wire logic [WIDTH-1:0] i_preset,   // stored preset
  output logic                  o_zero      // one-cycle pulse on zero
);
  logic [WIDTH-1:0] count_reg;

  // -------------------------------------------------
  // count down per tick, reload after zero
  // -------------------------------------------------
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      count_reg <= '0;
    end else if (i_tick) begin
      if (count_reg == '0) begin
        count_reg <= i_preset;
      end else begin
        count_reg <= count_reg - 1'b1;
      end
    end
  end

  // pulse marks the multi-phase cycle in which count holds zero
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_zero <= 1'b0;
    end else begin
      o_zero <= i_tick && (count_reg == '0);
    end
  end
endmodule

// File: hw/timebase_params.svh
`ifndef TIMEBASE_PARAMS_SVH
`define TIMEBASE_PARAMS_SVH
// register offsets (word index on the plain port)
`define OFF_SYSTEM_SETUP      8'h00
`define OFF_MULTI_WRITE_MASK  8'h01
`define OFF_ACCUM_IRQ_DIV     8'h02
`define OFF_EPOCH_DIV_UPPER   8'h03
`define OFF_EPOCH_DIV_LOWER   8'h04
`define OFF_CHAN_SOFT_RESET   8'h05
`define OFF_SNAPSHOT_TRIGGER  8'h06
`define OFF_STATE_READBACK    8'h07
// system setup field positions
`define BIT_IRQ_ENABLE        5
`define BIT_FRONT_END_MODE    6
`define BIT_IRQ_PERIOD        7
// channel reset field positions
`define BIT_SOFT_RESET_N      0
// interrupt presets
`define IRQ_PRESET_REAL_SHORT 13'h0B45
`define IRQ_PRESET_REAL_LONG  13'h1313
`define IRQ_PRESET_CPLX_SHORT 13'h0B81
`define IRQ_PRESET_CPLX_LONG  13'h1379
// epoch presets
`define EPOCH_PRESET_REAL     21'h08_B823
`define EPOCH_PRESET_CPLX     21'h08_E6A4
// multi-phase clock lengths in master clocks
`define PHASE_LEN_REAL        3'h7
`define PHASE_LEN_CPLX        3'h6
`endif

// File: hw/timebase_pkg.sv
package timebase_pkg;
  typedef enum logic [0:0] {
    MODE_REAL    = 1'b0,
    MODE_COMPLEX = 1'b1
  } input_mode_t;
endpackage
